// File: dv/sso_host_model.sv
// Host controller input stage that samples the status transistors.
`timescale 1ns/1ps

// ****************
// Host sampler
// ****************
module sso_host_model
(
  // Clock.
  input  wire logic        clk_in,
  // Transistor states from the driver.
  input  wire logic [13:0] pins_in,
  // Value the host last latched.
  output logic      [13:0] seen_out
);
  // Latching on an edge means a settling output is never misread.
  always_ff @(posedge clk_in)
    seen_out <= pins_in;
endmodule : sso_host_model

// File: dv/sso_props.sv
// Concurrent checks on the ports of the servo status output block.
`timescale 1ns/1ps

// ****************
// Checker
// ****************
module sso_props
(
  input wire logic                 clk_in,
  input wire logic                 rst_in,
  input wire sso_pkg::sso_status_t status_in,
  input wire sso_pkg::sso_link_t   link_in,
  input wire logic                 wb_cyc_in,
  input wire logic                 wb_stb_in,
  input wire logic                 wb_ack_out,
  input wire logic                 position_done_out,
  input wire logic                 position_done_alt_out,
  input wire logic                 zero_speed_out,
  input wire logic                 pos_cmd_active_out,
  input wire logic                 vel_cmd_active_out,
  input wire logic                 speed_limited_out,
  input wire logic                 clearable_alarm_out,
  input wire logic                 net_ctrl_out_a,
  input wire logic                 net_ctrl_out_b
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // A fresh request is answered by an acknowledge lasting one cycle.
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_pulse;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  chk_ack_pulse:
    assert property (s_req |=> s_pulse) else $error("ack not one pulse");
  chk_pos_done:
    assert property (status_in.pos_done && sso_pkg::MODES_POS_FC[status_in.mode]
      |=> position_done_out) else $error("position done missing");
  chk_mode_off:
    assert property (!sso_pkg::MODES_POS_FC[status_in.mode] |=> !position_done_out
      && !position_done_alt_out && !pos_cmd_active_out) else $error("mode gate");
  chk_zero_speed:
    assert property (status_in.zero_speed |=> zero_speed_out)
      else $error("zero speed missing");
  chk_pos_cmd:
    assert property (1'b1 |=> pos_cmd_active_out == $past(status_in.pos_cmd
      != 32'sh0 && sso_pkg::MODES_POS_FC[status_in.mode])) else $error("pos cmd");
  chk_vel_cmd:
    assert property (1'b1 |=> vel_cmd_active_out == $past(status_in.mode ==
      sso_pkg::SSO_MODE_VELOCITY && (status_in.vel_cmd >= 16'sh001e ||
      status_in.vel_cmd <= -16'sh001e))) else $error("vel cmd");
  chk_speed_lim:
    assert property (1'b1 |=> speed_limited_out == $past(status_in.speed_limited
      && status_in.mode == sso_pkg::SSO_MODE_TORQUE)) else $error("speed lim");
  chk_alarm_attr:
    assert property (1'b1 |=> clearable_alarm_out == $past(
      status_in.alarm_active && status_in.alarm_clearable)) else $error("alarm");
  chk_net_follow:
    assert property (link_in.up |=> net_ctrl_out_a == $past(link_in.ctrl_a)
      && net_ctrl_out_b == $past(link_in.ctrl_b)) else $error("net follow");
  chk_net_hold:
    assert property (!link_in.up |=> !$rose(net_ctrl_out_a)
      && !$rose(net_ctrl_out_b)) else $error("net rose while down");
endmodule : sso_props

bind sso_top sso_props u_props
(
  .clk_in(clk_in), .rst_in(rst_in), .status_in(status_in),
  .link_in(link_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_ack_out(wb_ack_out), .position_done_out(position_done_out),
  .position_done_alt_out(position_done_alt_out),
  .zero_speed_out(zero_speed_out), .pos_cmd_active_out(pos_cmd_active_out),
  .vel_cmd_active_out(vel_cmd_active_out),
  .speed_limited_out(speed_limited_out),
  .clearable_alarm_out(clearable_alarm_out),
  .net_ctrl_out_a(net_ctrl_out_a), .net_ctrl_out_b(net_ctrl_out_b)
);

// File: dv/tb.sv
// Self-checking bench for the servo status output block.
`timescale 1ns/1ps

// ****************
// Bench
// ****************
module tb;
  logic                 clk_in          = 1'b0;
  logic                 rst_in          = 1'b1;
  sso_pkg::sso_status_t st              = '0;
  sso_pkg::sso_link_t   lnk             = '0;
  logic                 cyc             = 1'b0;
  logic                 stb             = 1'b0;
  logic                 we              = 1'b0;
  logic [7:0]           adr             = 8'h00;
  logic [31:0]          wdat            = 32'h0000_0000;
  logic [31:0]          rdat;
  logic [31:0]          q;
  logic                 ack;
  logic                 irq;
  logic [13:0]          pins;
  logic [13:0]          seen;
  int                   mismatches      = 0;
  int                   samples_checked = 0;
  int                   cycles          = 0;

  // A 25 ns period gives the 40 MHz control clock.
  always #12.5 clk_in = ~clk_in;

  sso_top u_dut
  (
    .clk_in(clk_in), .rst_in(rst_in), .status_in(st), .link_in(lnk),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .irq_out(irq),
    .position_done_out(pins[0]), .speed_arrival_out(pins[1]),
    .torque_limited_out(pins[2]), .zero_speed_out(pins[3]),
    .speed_match_out(pins[4]), .position_done_alt_out(pins[5]),
    .warning_a_out(pins[6]), .warning_b_out(pins[7]),
    .pos_cmd_active_out(pins[8]), .vel_cmd_active_out(pins[9]),
    .speed_limited_out(pins[10]), .clearable_alarm_out(pins[11]),
    .net_ctrl_out_a(pins[12]), .net_ctrl_out_b(pins[13])
  );

  sso_host_model u_host (.clk_in(clk_in), .pins_in(pins), .seen_out(seen));

  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Three edges cover the output register plus the host's latch.
  task automatic settle();
    repeat (3) @(posedge clk_in);
  endtask : settle

  // One classic cycle; the request holds until ack is sampled high.
  // Only the bench timeout bounds the wait, so a slow slave is not cut.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_in);
    while (ack !== 1'b1)
      @(posedge clk_in);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_in);
  endtask : wb

  task automatic t_reset();
    check("pins after reset", seen, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      wb(1'b0, 8'(i * 4), 32'h0);
      check("reset register", q, 32'h0);
    end
    $display("reset test done");
  endtask : t_reset

  task automatic t_modes();
    logic [3:0]  pf;
    logic [3:0]  vt;
    logic [13:0] e;
    pf = sso_pkg::MODES_POS_FC;
    vt = sso_pkg::MODES_VEL_TQ;
    st <= '{mode: sso_pkg::SSO_MODE_POSITION, warnings: 16'h0001,
            pos_cmd: 32'sh5, vel_cmd: 16'sh1e, default: 1'b1};
    @(posedge clk_in);
    for (int m = 0; m < 4; m++)
    begin
      st.mode <= sso_pkg::sso_mode_t'(m);
      settle();
      e = {2'b00, 1'b1, sso_pkg::MODES_TQ[m], sso_pkg::MODES_VEL[m], pf[m],
           2'b11, pf[m], vt[m], 2'b11, vt[m], pf[m]};
      check("pins per mode", seen, e);
    end
    st.mode    <= sso_pkg::SSO_MODE_VELOCITY;
    st.vel_cmd <= 16'sh001d;
    settle();
    check("vel cmd 29", seen[9], 1'b0);
    st.vel_cmd <= -16'sh001e;
    settle();
    check("vel cmd -30", seen[9], 1'b1);
    st.mode            <= sso_pkg::SSO_MODE_POSITION;
    st.pos_cmd         <= 32'sh0;
    st.alarm_clearable <= 1'b0;
    settle();
    check("pos cmd zero", seen[8], 1'b0);
    check("alarm kept", seen[11], 1'b0);
    $display("mode test done");
  endtask : t_modes

  task automatic t_warn();
    st.warnings <= 16'h8000;
    wb(1'b1, sso_pkg::REG_WSEL_A, 32'h0000_000f);
    settle();
    check("warning a", seen[7:6], 2'b01);
    wb(1'b1, sso_pkg::REG_WSEL_B, 32'h0000_000f);
    settle();
    check("warning b", seen[7:6], 2'b11);
    wb(1'b0, sso_pkg::REG_WSEL_A, 32'h0);
    check("select readback", q, 32'h0000_000f);
    $display("warning test done");
  endtask : t_warn

  task automatic t_net();
    lnk <= '{up: 1'b0, ctrl_a: 1'b1, ctrl_b: 1'b1};
    settle();
    check("net before link", seen[13:12], 2'b00);
    lnk.up <= 1'b1;
    settle();
    check("net follow", seen[13:12], 2'b11);
    lnk.ctrl_a <= 1'b0;
    settle();
    check("net a follow", seen[13:12], 2'b10);
    lnk <= '{up: 1'b0, ctrl_a: 1'b1, ctrl_b: 1'b0};
    settle();
    check("net held", seen[13:12], 2'b10);
    lnk <= '{up: 1'b1, ctrl_a: 1'b1, ctrl_b: 1'b1};
    wb(1'b1, sso_pkg::REG_LINK_CFG, 32'h0000_0001);
    lnk.up <= 1'b0;
    settle();
    check("net a cleared", seen[13:12], 2'b10);
    lnk.up <= 1'b1;
    wb(1'b1, sso_pkg::REG_LINK_CFG, 32'h0000_0002);
    lnk.up <= 1'b0;
    settle();
    check("net b cleared", seen[13:12], 2'b01);
    $display("network test done");
  endtask : t_net

  task automatic t_irq();
    st.zero_speed <= 1'b0;
    wb(1'b1, sso_pkg::REG_IRQ_STAT, 32'h0000_3fff);
    st.zero_speed <= 1'b1;
    settle();
    wb(1'b0, sso_pkg::REG_IRQ_STAT, 32'h0);
    check("zero speed event", q, 32'h0000_0008);
    check("irq masked", irq, 1'b0);
    wb(1'b1, sso_pkg::REG_IRQ_MASK, 32'h0000_0008);
    check("irq raised", irq, 1'b1);
    wb(1'b1, sso_pkg::REG_IRQ_STAT, 32'h0000_0008);
    check("irq cleared", irq, 1'b0);
    // The output rises on the ack edge's eve, so its event meets the clear.
    st.zero_speed <= 1'b0;
    settle();
    st.zero_speed <= 1'b1;
    wb(1'b1, sso_pkg::REG_IRQ_STAT, 32'h0000_0008);
    wb(1'b0, sso_pkg::REG_IRQ_STAT, 32'h0);
    check("set beats clear", q, 32'h0000_0008);
    $display("interrupt test done");
  endtask : t_irq

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // Cuts a hang short well beyond the roughly 120 cycles the run needs.
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_modes();
    t_warn();
    t_net();
    t_irq();
    report_and_stop();
  end
endmodule : tb

// File: inc/sso_pkg.sv
// Package of constants and carrier types for the servo status output block.
package sso_pkg;

  // ******************************************************************
  // Bus geometry and register map (byte addresses)
  // ******************************************************************
  localparam int         ADDR_W        = 8;
  localparam int         DATA_W        = 32;
  localparam int         SEL_W         = 4;
  localparam logic [7:0] REG_WSEL_A    = 8'h00;
  localparam logic [7:0] REG_WSEL_B    = 8'h04;
  localparam logic [7:0] REG_LINK_CFG  = 8'h08;
  localparam logic [7:0] REG_OUT_STATE = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h14;

  // ******************************************************************
  // Field widths, positions and reset values
  // ******************************************************************
  localparam int          WARN_N         = 16;
  localparam int          WSEL_W         = 4;
  localparam int          NUM_OUT        = 14;
  localparam int          CFG_W          = 2;
  localparam int          CFG_CLR_A_BIT  = 0;
  localparam int          CFG_CLR_B_BIT  = 1;
  localparam logic [3:0]  WSEL_RST       = 4'h0;
  localparam logic [1:0]  CFG_RST        = 2'h0;
  localparam logic [13:0] OUT_RST        = 14'h0000;
  localparam logic [13:0] MASK_RST       = 14'h0000;
  localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;

  // Velocity command threshold in r/min; command is in r/min units.
  localparam logic [16:0] VEL_CMD_MIN_RPM = 17'h0001e;

  // ******************************************************************
  // Output bit positions in the output and interrupt vectors
  // ******************************************************************
  localparam int OUT_POS_DONE     = 0;
  localparam int OUT_SPEED_ARRIVE = 1;
  localparam int OUT_TORQUE_LIM   = 2;
  localparam int OUT_ZERO_SPEED   = 3;
  localparam int OUT_SPEED_MATCH  = 4;
  localparam int OUT_POS_DONE_ALT = 5;
  localparam int OUT_WARN_A       = 6;
  localparam int OUT_WARN_B       = 7;
  localparam int OUT_POS_CMD      = 8;
  localparam int OUT_VEL_CMD      = 9;
  localparam int OUT_SPEED_LIM    = 10;
  localparam int OUT_CLR_ALARM    = 11;
  localparam int OUT_NET_A        = 12;
  localparam int OUT_NET_B        = 13;

  // ******************************************************************
  // Control modes and per-output mode validity masks
  // ******************************************************************
  typedef enum logic [1:0] {
    SSO_MODE_POSITION,
    SSO_MODE_VELOCITY,
    SSO_MODE_TORQUE,
    SSO_MODE_FULL_CLOSE
  } sso_mode_t;

  // Bit n of a mask is set when the output is meaningful in mode n.
  localparam logic [3:0] MODES_POS_FC = 4'h9;
  localparam logic [3:0] MODES_VEL_TQ = 4'h6;
  localparam logic [3:0] MODES_ALL    = 4'hf;
  localparam logic [3:0] MODES_TQ     = 4'h4;
  localparam logic [3:0] MODES_VEL    = 4'h2;
  localparam logic [3:0] MODE_ONE     = 4'h1;

  // ******************************************************************
  // Carrier types
  // ******************************************************************
  typedef struct packed {
    sso_mode_t                mode;
    logic                     pos_done;
    logic                     pos_done_alt;
    logic                     speed_arrived;
    logic                     torque_limited;
    logic                     zero_speed;
    logic                     speed_match;
    logic                     speed_limited;
    logic                     alarm_active;
    logic                     alarm_clearable;
    logic [WARN_N-1:0]        warnings;
    logic signed [31:0]       pos_cmd;
    logic signed [15:0]       vel_cmd;
  } sso_status_t;

  typedef struct packed {
    logic up;
    logic ctrl_a;
    logic ctrl_b;
  } sso_link_t;

endpackage : sso_pkg

// File: src/sso_top.sv
// Servo status output logic with a classic Wishbone register slave.
//
// What this block does
// - Position-done output on when positioning finished.
// - Speed-arrival output on when speed reached.
// - Torque-limited output on while torque clamped.
// - Zero-speed output on while velocity is zero.
// - Speed-match output on when velocity matches command.
// - Alternate position-done on at second completion.
// - Warning A output follows selected warning A.
// - Warning B output follows selected warning B.
// - Position-command output on when command nonzero.
// - Velocity-command output on at 30 r/min.
// - Speed-limited output on while torque-mode clamping.
// - Clearable-alarm output on for clearable active alarm.
// - Network output A follows its link bit.
// - Network output B follows its link bit.
// - Outputs held off in modes without meaning.
// - Network outputs off until link; hold/clear.
`timescale 1ns/1ps

module sso_top
(
  // Clock and reset.
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  // Servo-control status and network link.
  input  wire sso_pkg::sso_status_t       status_in,
  input  wire sso_pkg::sso_link_t         link_in,
  // Wishbone classic slave.
  input  wire logic                       wb_cyc_in,
  input  wire logic                       wb_stb_in,
  input  wire logic                       wb_we_in,
  input  wire logic [sso_pkg::ADDR_W-1:0] wb_adr_in,
  input  wire logic [sso_pkg::SEL_W-1:0]  wb_sel_in,
  input  wire logic [sso_pkg::DATA_W-1:0] wb_dat_in,
  output logic      [sso_pkg::DATA_W-1:0] wb_dat_out,
  output logic                            wb_ack_out,
  // Interrupt.
  output logic                            irq_out,
  // Status outputs toward the host controller.
  output logic                            position_done_out,
  output logic                            speed_arrival_out,
  output logic                            torque_limited_out,
  output logic                            zero_speed_out,
  output logic                            speed_match_out,
  output logic                            position_done_alt_out,
  output logic                            warning_a_out,
  output logic                            warning_b_out,
  output logic                            pos_cmd_active_out,
  output logic                            vel_cmd_active_out,
  output logic                            speed_limited_out,
  output logic                            clearable_alarm_out,
  output logic                            net_ctrl_out_a,
  output logic                            net_ctrl_out_b
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  logic [sso_pkg::WSEL_W-1:0]  warning_select_a;
  logic [sso_pkg::WSEL_W-1:0]  warning_select_b;
  logic [sso_pkg::CFG_W-1:0]   link_enhance_cfg;
  logic [sso_pkg::NUM_OUT-1:0] out_state;
  logic [sso_pkg::NUM_OUT-1:0] out_prev;
  logic [sso_pkg::NUM_OUT-1:0] next_out;
  logic [sso_pkg::NUM_OUT-1:0] irq_stat;
  logic [sso_pkg::NUM_OUT-1:0] irq_mask;
  logic [sso_pkg::NUM_OUT-1:0] out_event;
  logic [sso_pkg::NUM_OUT-1:0] stat_clr;
  logic [3:0]                  mode_bit;
  logic [16:0]                 vel_mag;
  logic                        bus_req;
  logic                        bus_wr;
  logic [sso_pkg::DATA_W-1:0]  wr_mask;
  logic [sso_pkg::DATA_W-1:0]  next_rdata;
  logic                        next_net_a;
  logic                        next_net_b;

  // ******************************************************************
  // Status output generation
  // ******************************************************************

  // One-hot of the active mode, used to gate the mode-dependent outputs by their mode masks.
  assign mode_bit = 4'(sso_pkg::MODE_ONE << status_in.mode);

  // Magnitude of the velocity command, widened so the most negative value
  // cannot wrap back to a small number.
  assign vel_mag = status_in.vel_cmd[15] ?
                   17'(-{status_in.vel_cmd[15], status_in.vel_cmd}) :
                   17'({1'b0, status_in.vel_cmd});

  // Conditions for every output; all but the warning, clearable-alarm and network outputs are gated by the modes where they apply.
  always_comb
  begin
    next_out = sso_pkg::OUT_RST;
    next_out[sso_pkg::OUT_POS_DONE] = status_in.pos_done &
      |(mode_bit & sso_pkg::MODES_POS_FC);
    next_out[sso_pkg::OUT_SPEED_ARRIVE] = status_in.speed_arrived &
      |(mode_bit & sso_pkg::MODES_VEL_TQ);
    next_out[sso_pkg::OUT_TORQUE_LIM] = status_in.torque_limited &
      |(mode_bit & sso_pkg::MODES_ALL);
    next_out[sso_pkg::OUT_ZERO_SPEED] = status_in.zero_speed &
      |(mode_bit & sso_pkg::MODES_ALL);
    next_out[sso_pkg::OUT_SPEED_MATCH] = status_in.speed_match &
      |(mode_bit & sso_pkg::MODES_VEL_TQ);
    next_out[sso_pkg::OUT_POS_DONE_ALT] = status_in.pos_done_alt &
      |(mode_bit & sso_pkg::MODES_POS_FC);
    next_out[sso_pkg::OUT_WARN_A] =
      status_in.warnings[warning_select_a];
    next_out[sso_pkg::OUT_WARN_B] =
      status_in.warnings[warning_select_b];
    next_out[sso_pkg::OUT_POS_CMD] = (status_in.pos_cmd != 32'sh0) &
      |(mode_bit & sso_pkg::MODES_POS_FC);
    next_out[sso_pkg::OUT_VEL_CMD] =
      (vel_mag >= sso_pkg::VEL_CMD_MIN_RPM) &
      |(mode_bit & sso_pkg::MODES_VEL);
    next_out[sso_pkg::OUT_SPEED_LIM] = status_in.speed_limited &
      |(mode_bit & sso_pkg::MODES_TQ);
    next_out[sso_pkg::OUT_CLR_ALARM] = status_in.alarm_active &
      status_in.alarm_clearable;
    next_out[sso_pkg::OUT_NET_A] = next_net_a;
    next_out[sso_pkg::OUT_NET_B] = next_net_b;
  end

  // Network outputs follow their bits only while the link is up. Reset
  // clears them and, with the link never up, holding keeps them off; a
  // shutdown either holds the last value or clears it per config bit.
  always_comb
  begin
    next_net_a = out_state[sso_pkg::OUT_NET_A];
    next_net_b = out_state[sso_pkg::OUT_NET_B];
    if (link_in.up)
    begin
      next_net_a = link_in.ctrl_a;
      next_net_b = link_in.ctrl_b;
    end
    else
    begin
      if (link_enhance_cfg[sso_pkg::CFG_CLR_A_BIT])
        next_net_a = 1'b0;
      if (link_enhance_cfg[sso_pkg::CFG_CLR_B_BIT])
        next_net_b = 1'b0;
    end
  end

  // Output register; all outputs off while reset is held.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      out_state <= sso_pkg::OUT_RST;
      out_prev  <= sso_pkg::OUT_RST;
    end
    else
    begin
      out_state <= next_out;
      out_prev  <= out_state;
    end
  end

  assign position_done_out     = out_state[sso_pkg::OUT_POS_DONE];
  assign speed_arrival_out     = out_state[sso_pkg::OUT_SPEED_ARRIVE];
  assign torque_limited_out    = out_state[sso_pkg::OUT_TORQUE_LIM];
  assign zero_speed_out        = out_state[sso_pkg::OUT_ZERO_SPEED];
  assign speed_match_out       = out_state[sso_pkg::OUT_SPEED_MATCH];
  assign position_done_alt_out = out_state[sso_pkg::OUT_POS_DONE_ALT];
  assign warning_a_out         = out_state[sso_pkg::OUT_WARN_A];
  assign warning_b_out         = out_state[sso_pkg::OUT_WARN_B];
  assign pos_cmd_active_out    = out_state[sso_pkg::OUT_POS_CMD];
  assign vel_cmd_active_out    = out_state[sso_pkg::OUT_VEL_CMD];
  assign speed_limited_out     = out_state[sso_pkg::OUT_SPEED_LIM];
  assign clearable_alarm_out   = out_state[sso_pkg::OUT_CLR_ALARM];
  assign net_ctrl_out_a        = out_state[sso_pkg::OUT_NET_A];
  assign net_ctrl_out_b        = out_state[sso_pkg::OUT_NET_B];

  // ******************************************************************
  // Wishbone slave
  // ******************************************************************

  // A write lands on the edge where the master sees ack, so the master's
  // sampling edge and the register update coincide.
  assign bus_req = wb_cyc_in & wb_stb_in;
  assign bus_wr  = bus_req & wb_we_in & wb_ack_out;
  assign wr_mask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                    {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

  // Ack one cycle after the request, dropped in the following cycle.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      wb_ack_out <= 1'b0;
    else
      wb_ack_out <= bus_req & ~wb_ack_out;
  end

  // Read mux; unmapped addresses read as zero and are still acknowledged.
  always_comb
  begin
    next_rdata = sso_pkg::RDATA_ZERO;
    case (wb_adr_in)
      sso_pkg::REG_WSEL_A:    next_rdata[sso_pkg::WSEL_W-1:0] =
                                warning_select_a;
      sso_pkg::REG_WSEL_B:    next_rdata[sso_pkg::WSEL_W-1:0] =
                                warning_select_b;
      sso_pkg::REG_LINK_CFG:  next_rdata[sso_pkg::CFG_W-1:0] =
                                link_enhance_cfg;
      sso_pkg::REG_OUT_STATE: next_rdata[sso_pkg::NUM_OUT-1:0] = out_state;
      sso_pkg::REG_IRQ_STAT:  next_rdata[sso_pkg::NUM_OUT-1:0] = irq_stat;
      sso_pkg::REG_IRQ_MASK:  next_rdata[sso_pkg::NUM_OUT-1:0] = irq_mask;
      default:                next_rdata = sso_pkg::RDATA_ZERO;
    endcase
  end

  // Read data is captured with the ack and holds until the next request captures it.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      wb_dat_out <= sso_pkg::RDATA_ZERO;
    else if (bus_req & ~wb_ack_out)
      wb_dat_out <= next_rdata;
  end

  // Configuration registers written under the byte lane mask.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      warning_select_a <= sso_pkg::WSEL_RST;
      warning_select_b <= sso_pkg::WSEL_RST;
      link_enhance_cfg <= sso_pkg::CFG_RST;
      irq_mask         <= sso_pkg::MASK_RST;
    end
    else if (bus_wr)
    begin
      case (wb_adr_in)
        sso_pkg::REG_WSEL_A:
          warning_select_a <= (warning_select_a &
            ~wr_mask[sso_pkg::WSEL_W-1:0]) |
            (wb_dat_in[sso_pkg::WSEL_W-1:0] &
             wr_mask[sso_pkg::WSEL_W-1:0]);
        sso_pkg::REG_WSEL_B:
          warning_select_b <= (warning_select_b &
            ~wr_mask[sso_pkg::WSEL_W-1:0]) |
            (wb_dat_in[sso_pkg::WSEL_W-1:0] &
             wr_mask[sso_pkg::WSEL_W-1:0]);
        sso_pkg::REG_LINK_CFG:
          link_enhance_cfg <= (link_enhance_cfg &
            ~wr_mask[sso_pkg::CFG_W-1:0]) |
            (wb_dat_in[sso_pkg::CFG_W-1:0] &
             wr_mask[sso_pkg::CFG_W-1:0]);
        sso_pkg::REG_IRQ_MASK:
          irq_mask <= (irq_mask & ~wr_mask[sso_pkg::NUM_OUT-1:0]) |
            (wb_dat_in[sso_pkg::NUM_OUT-1:0] &
             wr_mask[sso_pkg::NUM_OUT-1:0]);
        default:
          irq_mask <= irq_mask;
      endcase
    end
  end

  // ******************************************************************
  // Interrupt status
  // ******************************************************************

  // An event is an output switching on; a write of one clears the bit.
  assign out_event = out_state & ~out_prev;
  assign stat_clr  = (bus_wr && wb_adr_in == sso_pkg::REG_IRQ_STAT) ?
                     (wb_dat_in[sso_pkg::NUM_OUT-1:0] &
                      wr_mask[sso_pkg::NUM_OUT-1:0]) : sso_pkg::OUT_RST;

  // Per-bit sticky flags; a new event beats a clear in the same cycle.
  for (genvar i = 0; i < sso_pkg::NUM_OUT; i++)
  begin : g_irq
    always_ff @(posedge clk_in)
    begin
      if (rst_in)
        irq_stat[i] <= 1'b0;
      else if (out_event[i])
        irq_stat[i] <= 1'b1;
      else if (stat_clr[i])
        irq_stat[i] <= 1'b0;
    end
  end

  assign irq_out = |(irq_stat & irq_mask);

endmodule : sso_top
